// file: hw/apcc_pkg.sv
/*
 * Constants and carrier types of the audio clock configuration block.
 * Assumes a single 250 MHz system clock and a byte-wide register port.
 */
package apcc_pkg;

    // Clock and timing
    localparam int  CLK_MHZ          = 250;
    localparam int  IDLE_TIMEOUT_US  = 200;
    localparam int  IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_US * CLK_MHZ;
    localparam int  RATE_SPLIT_KHZ   = 72;
    localparam logic [15:0] RATE_SPLIT_CYC = 16'((CLK_MHZ * 1000) / RATE_SPLIT_KHZ);
    localparam logic [31:0] FS_RATIO       = 32'h0000_0800;
    localparam logic [31:0] FRAC_SCALE     = 32'h0000_2710;

    // Register offsets
    localparam logic [7:0] OFS_PLL_ENABLE   = 8'h04;
    localparam logic [7:0] OFS_MASTER_CTRL  = 8'h09;
    localparam logic [7:0] OFS_REF_SELECT   = 8'h0D;
    localparam logic [7:0] OFS_PRE_DIV      = 8'h14;
    localparam logic [7:0] OFS_INT_FACTOR   = 8'h15;
    localparam logic [7:0] OFS_FRAC_UPPER   = 8'h16;
    localparam logic [7:0] OFS_FRAC_LOWER   = 8'h17;
    localparam logic [7:0] OFS_POST_MUL     = 8'h18;
    localparam logic [7:0] OFS_PROC_DIV     = 8'h1B;
    localparam logic [7:0] OFS_BITCLK_DIV   = 8'h20;
    localparam logic [7:0] OFS_WORDCLK_DIV  = 8'h21;
    localparam logic [7:0] OFS_AUTO_CTRL    = 8'h25;
    localparam logic [7:0] OFS_STATUS       = 8'h5E;

    // Field positions
    localparam int REF_SEL_LSB   = 4;
    localparam int AUTO_OFF_BIT  = 0;
    localparam int IGN_ERR_BIT   = 1;
    localparam int ST_DOUBLE_BIT = 0;
    localparam int ST_VALID_BIT  = 1;
    localparam int ST_FAULT_BIT  = 2;
    localparam int ST_RAT_OK_BIT = 3;
    localparam int ST_RATIO_LSB  = 4;

    // Reset values
    localparam logic       RST_PLL_ON  = 1'b1;
    localparam logic [2:0] RST_REF_SEL = 3'h0;
    localparam logic [3:0] RST_PDIV    = 4'h1;
    localparam logic [5:0] RST_JINT    = 6'h08;
    localparam logic [5:0] RST_DUP     = 6'h00;
    localparam logic [7:0] RST_DLO     = 8'h00;
    localparam logic [3:0] RST_RMUL    = 4'h0;
    localparam logic [6:0] RST_PDSP    = 7'h01;
    localparam logic [6:0] RST_BDIV    = 7'h07;
    localparam logic [7:0] RST_WDIV    = 8'h3F;

    // Reference source codes
    localparam logic [2:0] REF_MCLK = 3'h0;
    localparam logic [2:0] REF_SCLK = 3'h1;
    localparam logic [2:0] REF_GPIO = 3'h3;

    // Pin indices in the sampled pin vector
    localparam int PIN_MCLK = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_LRCK = 2;
    localparam int PIN_GPIO = 3;
    localparam int NPINS    = 4;

    // Measured system clock to sample rate ratio
    typedef enum logic [2:0] {
        RAT_64, RAT_128, RAT_192, RAT_256, RAT_384, RAT_512
    } apcc_ratio_t;

    // Ratio class boundaries in system clock edges per frame
    localparam logic [9:0] RAT_LIM_128 = 10'h060;
    localparam logic [9:0] RAT_LIM_192 = 10'h0A0;
    localparam logic [9:0] RAT_LIM_256 = 10'h0E0;
    localparam logic [9:0] RAT_LIM_384 = 10'h140;
    localparam logic [9:0] RAT_LIM_512 = 10'h1C0;

    // Register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } apcc_req_t;

    // Clock selections for filter, modulator and charge pump
    typedef struct packed {
        logic filter_double;
        logic dsm_double;
        logic ncp_double;
    } apcc_sel_t;

endpackage : apcc_pkg

// file: hw/apcc_clock_config.sv
/*
 * Clock detection and configuration of a stereo audio amplifier: rate sensing,
 * automatic clock tree setup, fractional synthesiser rate model, processor
 * clock divider and clock-master bit and word clock generation.
 * Assumes pins arrive asynchronously and are at most a fifth of clk in rate;
 * the register port is synchronous to clk.
 */
// Operation
// - Sense applied system clock frequency automatically, up to 50 MHz.
// - 88.2/96 kHz are double rate; 32/44.1/48 kHz single rate.
// - With all three clocks valid, configure clock tree and synthesiser automatically.
// - Detected rate selects filter, modulator and charge pump clocks.
// - Software can suppress clock error detection during configuration.
// - Advanced master mode drives bit and word clocks from non-audio reference.
// - Accept 256/384/512x directly; 128/192x only via synthesiser; never 64x.
// - Synthesiser reference from bit clock, system clock or general pin, 3-bit field.
// - Clearing enable stops the synthesiser; external master clock then needed.
// - Synthesiser enable resets to enabled.
// - Output equals input times R times J.D divided by P.
// - R 1..16, J 4..63, D 0..9999, P 1..15.
// - J is integer part, D four-digit decimal fraction of the factor.
// - Sample rate equals synthesiser output divided by 2048.
// - 7-bit processor, 7-bit bit clock and 8-bit word clock dividers.
// - P 4 bits, J 6 bits, D split 6 upper and 8 lower, R 4 bits.
// - Generated master clock is fed back on the system clock pin and divided.
`timescale 1ns/1ps
`default_nettype none

module apcc_clock_config #(
    parameter int IDLE_TIMEOUT = apcc_pkg::IDLE_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               sys_rst,
    // Register port
    input  wire apcc_pkg::apcc_req_t req,
    output logic [7:0]              rdata,
    // Clock pins
    input  wire logic               mclk_in,
    input  wire logic               sclk_in,
    input  wire logic               lrck_in,
    input  wire logic               gpio_ref_in,
    output logic                    sclk_out,
    output logic                    sclk_oe_n,
    output logic                    lrck_out,
    output logic                    lrck_oe_n,
    // Clock tree results
    output apcc_pkg::apcc_sel_t     clk_sel,
    output logic                    auto_active,
    output logic                    clk_fault,
    output logic                    dsp_clk_en,
    output logic                    fs_tick
);

    typedef struct packed {
        logic [apcc_pkg::NPINS-1:0] s1;
        logic [apcc_pkg::NPINS-1:0] s2;
        logic [apcc_pkg::NPINS-1:0] prv;
        logic        pll_on;
        logic [2:0]  ref_sel;
        logic [3:0]  pdiv;
        logic [5:0]  jint;
        logic [5:0]  dup;
        logic [7:0]  dlo;
        logic [3:0]  rmul;
        logic [6:0]  pdsp;
        logic [6:0]  bdiv;
        logic [7:0]  wdiv;
        logic        auto_off;
        logic        ign_err;
        logic        master;
        logic        oe_n;
        logic [15:0] lr_per;
        logic [9:0]  mc_cnt;
        logic [15:0] idle_m;
        logic [15:0] idle_s;
        logic [15:0] idle_l;
        logic        rate_double;
        apcc_pkg::apcc_ratio_t ratio;
        logic        ratio_ok;
        logic        valid;
        logic        fault;
        logic        auto_act;
        logic [31:0] acc;
        logic        fs;
        logic [6:0]  dcnt;
        logic        den;
        logic [6:0]  bcnt;
        logic [7:0]  wcnt;
        logic        bclk;
        logic        wclk;
        logic [7:0]  rd;
    } apcc_state_t;

    apcc_state_t st_reg;
    apcc_state_t st_next;

    logic [apcc_pkg::NPINS-1:0] rise;
    logic        ref_edge;
    logic [31:0] kfac;
    logic [31:0] step;
    logic [31:0] limit;
    logic [31:0] acc_sum;
    logic [3:0]  pval;
    logic [6:0]  bhalf;
    logic [15:0] tmo;

    assign tmo = 16'(IDLE_TIMEOUT);

    always_comb begin
        st_next = st_reg;
        rise    = st_reg.s2 & ~st_reg.prv;

        // Pin synchronisers
        st_next.s1  = {gpio_ref_in, lrck_in, sclk_in, mclk_in};
        st_next.s2  = st_reg.s1;
        st_next.prv = st_reg.s2;

        // Register writes
        if (req.wr) begin
            unique case (req.addr)
                apcc_pkg::OFS_PLL_ENABLE:  st_next.pll_on = req.wdata[0];
                apcc_pkg::OFS_MASTER_CTRL: st_next.master = req.wdata[0];
                apcc_pkg::OFS_REF_SELECT:  st_next.ref_sel = req.wdata[apcc_pkg::REF_SEL_LSB +: 3];
                apcc_pkg::OFS_PRE_DIV:     st_next.pdiv = req.wdata[3:0];
                apcc_pkg::OFS_INT_FACTOR:  st_next.jint = req.wdata[5:0];
                apcc_pkg::OFS_FRAC_UPPER:  st_next.dup = req.wdata[5:0];
                apcc_pkg::OFS_FRAC_LOWER:  st_next.dlo = req.wdata;
                apcc_pkg::OFS_POST_MUL:    st_next.rmul = req.wdata[3:0];
                apcc_pkg::OFS_PROC_DIV:    st_next.pdsp = req.wdata[6:0];
                apcc_pkg::OFS_BITCLK_DIV:  st_next.bdiv = req.wdata[6:0];
                apcc_pkg::OFS_WORDCLK_DIV: st_next.wdiv = req.wdata;
                apcc_pkg::OFS_AUTO_CTRL: begin
                    st_next.auto_off = req.wdata[apcc_pkg::AUTO_OFF_BIT];
                    st_next.ign_err  = req.wdata[apcc_pkg::IGN_ERR_BIT];
                end
                default: ;
            endcase
        end

        // Register reads, unmapped and reserved bits read zero
        if (req.rd) begin
            unique case (req.addr)
                apcc_pkg::OFS_PLL_ENABLE:  st_next.rd = {7'h00, st_reg.pll_on};
                apcc_pkg::OFS_MASTER_CTRL: st_next.rd = {7'h00, st_reg.master};
                apcc_pkg::OFS_REF_SELECT:  st_next.rd = {1'b0, st_reg.ref_sel, 4'h0};
                apcc_pkg::OFS_PRE_DIV:     st_next.rd = {4'h0, st_reg.pdiv};
                apcc_pkg::OFS_INT_FACTOR:  st_next.rd = {2'h0, st_reg.jint};
                apcc_pkg::OFS_FRAC_UPPER:  st_next.rd = {2'h0, st_reg.dup};
                apcc_pkg::OFS_FRAC_LOWER:  st_next.rd = st_reg.dlo;
                apcc_pkg::OFS_POST_MUL:    st_next.rd = {4'h0, st_reg.rmul};
                apcc_pkg::OFS_PROC_DIV:    st_next.rd = {1'b0, st_reg.pdsp};
                apcc_pkg::OFS_BITCLK_DIV:  st_next.rd = {1'b0, st_reg.bdiv};
                apcc_pkg::OFS_WORDCLK_DIV: st_next.rd = st_reg.wdiv;
                apcc_pkg::OFS_AUTO_CTRL:   st_next.rd = {6'h00, st_reg.ign_err, st_reg.auto_off};
                apcc_pkg::OFS_STATUS:      st_next.rd = {1'b0, st_reg.ratio, st_reg.ratio_ok,
                                                         st_reg.fault, st_reg.valid, st_reg.rate_double};
                default:                   st_next.rd = 8'h00;
            endcase
        end

        // Activity watchdogs on the three serial clocks
        st_next.idle_m = rise[apcc_pkg::PIN_MCLK] ? 16'h0000 :
                         (st_reg.idle_m < tmo) ? st_reg.idle_m + 16'h0001 : st_reg.idle_m;
        st_next.idle_s = rise[apcc_pkg::PIN_SCLK] ? 16'h0000 :
                         (st_reg.idle_s < tmo) ? st_reg.idle_s + 16'h0001 : st_reg.idle_s;
        st_next.idle_l = rise[apcc_pkg::PIN_LRCK] ? 16'h0000 :
                         (st_reg.idle_l < tmo) ? st_reg.idle_l + 16'h0001 : st_reg.idle_l;
        st_next.valid  = (st_reg.idle_m < tmo) && (st_reg.idle_s < tmo) && (st_reg.idle_l < tmo);
        st_next.fault  = !st_reg.valid && !st_reg.ign_err;

        // Frame measurement: frame length in clk and system clock edges per frame
        if (rise[apcc_pkg::PIN_LRCK]) begin
            st_next.lr_per      = 16'h0001;
            st_next.mc_cnt      = 10'h000;
            st_next.rate_double = st_reg.lr_per < apcc_pkg::RATE_SPLIT_CYC;
            // Ratio class of the sensed system clock
            if (st_reg.mc_cnt < apcc_pkg::RAT_LIM_128)      st_next.ratio = apcc_pkg::RAT_64;
            else if (st_reg.mc_cnt < apcc_pkg::RAT_LIM_192) st_next.ratio = apcc_pkg::RAT_128;
            else if (st_reg.mc_cnt < apcc_pkg::RAT_LIM_256) st_next.ratio = apcc_pkg::RAT_192;
            else if (st_reg.mc_cnt < apcc_pkg::RAT_LIM_384) st_next.ratio = apcc_pkg::RAT_256;
            else if (st_reg.mc_cnt < apcc_pkg::RAT_LIM_512) st_next.ratio = apcc_pkg::RAT_384;
            else                                            st_next.ratio = apcc_pkg::RAT_512;
        end else begin
            if (st_reg.lr_per != 16'hFFFF) st_next.lr_per = st_reg.lr_per + 16'h0001;
            if (rise[apcc_pkg::PIN_MCLK] && st_reg.mc_cnt != 10'h3FF)
                st_next.mc_cnt = st_reg.mc_cnt + 10'h001;
        end

        // Ratio support check
        unique case (st_reg.ratio)
            apcc_pkg::RAT_64:  st_next.ratio_ok = 1'b0;
            apcc_pkg::RAT_128: st_next.ratio_ok = st_reg.pll_on;
            apcc_pkg::RAT_192: st_next.ratio_ok = st_reg.pll_on && !st_reg.rate_double;
            default:           st_next.ratio_ok = 1'b1;
        endcase

        // Automatic clock tree configuration
        st_next.auto_act = !st_reg.auto_off && st_reg.valid;

        // Pin drivers enabled only in master mode
        st_next.oe_n = !st_reg.master;

        // Synthesiser reference edge
        if (st_reg.auto_act)
            ref_edge = rise[apcc_pkg::PIN_MCLK];
        else begin
            unique case (st_reg.ref_sel)
                apcc_pkg::REF_SCLK: ref_edge = rise[apcc_pkg::PIN_SCLK];
                apcc_pkg::REF_GPIO: ref_edge = rise[apcc_pkg::PIN_GPIO];
                default:            ref_edge = rise[apcc_pkg::PIN_MCLK];
            endcase
        end

        // Fractional rate model, in units of 1/(10000*P) output cycles
        pval    = (st_reg.pdiv == 4'h0) ? 4'h1 : st_reg.pdiv;
        kfac    = 32'(st_reg.jint) * apcc_pkg::FRAC_SCALE + 32'({st_reg.dup, st_reg.dlo});
        step    = kfac * 32'({1'b0, st_reg.rmul} + 5'h01);
        limit   = apcc_pkg::FS_RATIO * apcc_pkg::FRAC_SCALE * 32'(pval);
        acc_sum = st_reg.acc + step;
        st_next.fs = 1'b0;
        if (!st_reg.pll_on) begin
            st_next.acc = 32'h0000_0000;
        end else if (ref_edge) begin
            if (acc_sum >= limit) begin
                st_next.acc = acc_sum - limit;
                st_next.fs  = 1'b1;
            end else begin
                st_next.acc = acc_sum;
            end
        end

        // Processor clock divider on the reference edges
        st_next.den = 1'b0;
        if (ref_edge && st_reg.pll_on) begin
            if (st_reg.dcnt >= st_reg.pdsp) begin
                st_next.dcnt = 7'h00;
                st_next.den  = 1'b1;
            end else begin
                st_next.dcnt = st_reg.dcnt + 7'h01;
            end
        end

        // Master bit and word clocks from the fed-back system clock pin
        bhalf = 7'((8'({1'b0, st_reg.bdiv}) + 8'h01) >> 1);
        if (!st_reg.master) begin
            st_next.bcnt = 7'h00;
            st_next.wcnt = 8'h00;
            st_next.bclk = 1'b0;
            st_next.wclk = 1'b0;
        end else if (rise[apcc_pkg::PIN_MCLK]) begin
            if (st_reg.bcnt >= st_reg.bdiv) begin
                st_next.bcnt = 7'h00;
                st_next.bclk = 1'b1;
                if (st_reg.wcnt >= st_reg.wdiv) st_next.wcnt = 8'h00;
                else st_next.wcnt = st_reg.wcnt + 8'h01;
                st_next.wclk = (st_next.wcnt < 8'((9'({1'b0, st_reg.wdiv}) + 9'h001) >> 1));
            end else begin
                st_next.bcnt = st_reg.bcnt + 7'h01;
                st_next.bclk = (st_reg.bcnt + 7'h01) < bhalf;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg          <= '0;
            st_reg.pll_on   <= apcc_pkg::RST_PLL_ON;
            st_reg.ref_sel  <= apcc_pkg::RST_REF_SEL;
            st_reg.pdiv     <= apcc_pkg::RST_PDIV;
            st_reg.jint     <= apcc_pkg::RST_JINT;
            st_reg.dup      <= apcc_pkg::RST_DUP;
            st_reg.dlo      <= apcc_pkg::RST_DLO;
            st_reg.rmul     <= apcc_pkg::RST_RMUL;
            st_reg.pdsp     <= apcc_pkg::RST_PDSP;
            st_reg.bdiv     <= apcc_pkg::RST_BDIV;
            st_reg.wdiv     <= apcc_pkg::RST_WDIV;
            st_reg.ratio    <= apcc_pkg::RAT_256;
            st_reg.ratio_ok <= 1'b1;
            st_reg.oe_n     <= 1'b1;
            // No clock seen yet after reset
            st_reg.idle_m   <= 16'(IDLE_TIMEOUT);
            st_reg.idle_s   <= 16'(IDLE_TIMEOUT);
            st_reg.idle_l   <= 16'(IDLE_TIMEOUT);
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from state flops
    assign rdata       = st_reg.rd;
    assign sclk_out    = st_reg.bclk;
    assign lrck_out    = st_reg.wclk;
    assign sclk_oe_n   = st_reg.oe_n;
    assign lrck_oe_n   = st_reg.oe_n;
    assign clk_sel     = '{filter_double: st_reg.rate_double, dsm_double: st_reg.rate_double,
                           ncp_double: st_reg.rate_double};
    assign auto_active = st_reg.auto_act;
    assign clk_fault   = st_reg.fault;
    assign dsp_clk_en  = st_reg.den;
    assign fs_tick     = st_reg.fs;

endmodule // apcc_clock_config

`default_nettype wire

// file: verification/apcc_clock_config_monitor.sv
/*
 * Port checker of the audio clock configuration block.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module apcc_clock_config_monitor #(
    parameter int IDLE_TIMEOUT = 50000
) (
    // Clock and reset
    input wire logic                clk,
    input wire logic                sys_rst,
    // Register port
    input wire apcc_pkg::apcc_req_t req,
    input wire logic [7:0]          rdata,
    // Clock pins
    input wire logic                mclk_in,
    input wire logic                sclk_in,
    input wire logic                lrck_in,
    input wire logic                gpio_ref_in,
    input wire logic                sclk_out,
    input wire logic                sclk_oe_n,
    input wire logic                lrck_out,
    input wire logic                lrck_oe_n,
    // Clock tree results
    input wire apcc_pkg::apcc_sel_t clk_sel,
    input wire logic                auto_active,
    input wire logic                clk_fault,
    input wire logic                dsp_clk_en,
    input wire logic                fs_tick
);
    logic pll_on_q, ign_q, auto_off_q, master_q;

    // Shadow of the control bits written by the host
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {pll_on_q, ign_q, auto_off_q, master_q} <= 4'h8;
        end else if (req.wr) begin
            if (req.addr == 8'h04) pll_on_q <= req.wdata[0];
            if (req.addr == 8'h09) master_q <= req.wdata[0];
            if (req.addr == 8'h25) {ign_q, auto_off_q} <= req.wdata[1:0];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    ref_sel_mask_a: assert property (req.rd && req.addr == 8'h0D |=> (rdata & 8'h8F) == 8'h00)
        else $error("reference select reads back stray bits");
    coef_mask_a: assert property (req.rd && (req.addr == 8'h14 || req.addr == 8'h18) |=> rdata[7:4] == 4'h0)
        else $error("four-bit coefficient reads back stray bits");
    frac_mask_a: assert property (req.rd && (req.addr == 8'h15 || req.addr == 8'h16) |=> rdata[7:6] == 2'h0)
        else $error("six-bit coefficient reads back stray bits");
    div_mask_a: assert property (req.rd && (req.addr == 8'h1B || req.addr == 8'h20) |=> !rdata[7])
        else $error("seven-bit divider reads back stray bit");
    rdata_hold_a: assert property (!req.rd |=> $stable(rdata))
        else $error("read data moved without a read");
    pll_off_a: assert property (!pll_on_q [*3] |-> !fs_tick && !dsp_clk_en)
        else $error("stopped synthesiser still pulses");
    fault_ign_a: assert property (ign_q [*3] |-> !clk_fault)
        else $error("clock fault raised while ignored");
    auto_off_a: assert property (auto_off_q [*3] |-> !auto_active)
        else $error("auto configuration runs while disabled");
    sel_same_a: assert property (clk_sel.filter_double == clk_sel.dsm_double
                                 && clk_sel.dsm_double == clk_sel.ncp_double)
        else $error("clock selections disagree");
    oe_slave_a: assert property (!master_q [*3] |-> sclk_oe_n && lrck_oe_n)
        else $error("clock pins driven outside master mode");
    tick_pulse_a: assert property (fs_tick |=> !fs_tick)
        else $error("sample tick longer than one cycle");

    cover property (auto_active);
    cover property (fs_tick);
    cover property (clk_fault);
    cover property (!sclk_oe_n);
endmodule // apcc_clock_config_monitor

`default_nettype wire

// file: verification/apcc_audio_host.sv
/*
 * Serial audio host model: system, bit and word clocks plus a spare reference.
 * Assumes the bench sets half period and ratio; clocks stand still when run is low.
 */
`timescale 1ns/1ps
`default_nettype none

module apcc_audio_host (
    // Control
    input wire logic        run,
    input wire logic [15:0] half_ps,
    input wire logic [9:0]  ratio,
    // Clocks
    output logic            mclk,
    output logic            sclk,
    output logic            lrck,
    output logic            gref
);
    logic [9:0] k;

    initial begin
        {mclk, sclk, lrck, gref} = 4'h0;
        k = 10'h000;
    end

    // Host keeps supplying the master clock
    always begin
        if (!run) begin
            #1;
        end else begin
            #(half_ps / 1000.0) mclk = 1'b1;
            gref = ~gref;
            k = (k + 10'h001) % ratio;
            lrck = (k >= ratio / 2);
            sclk = ((k % (ratio >> 6)) >= (ratio >> 7));
            #(half_ps / 1000.0) mclk = 1'b0;
        end
    end
endmodule // apcc_audio_host

`default_nettype wire

// file: verification/test_audio_pll_clock_config.sv
/*
 * Self-checking bench of the audio clock configuration block.
 * Assumes the design and the host model; in master mode the pins carry the block's own clocks.
 */
`timescale 1ns/1ps
`default_nettype none

module test_audio_pll_clock_config;
    localparam logic [7:0] RA [10] = '{8'h04, 8'h0D, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1B, 8'h20, 8'h21};
    localparam logic [7:0] RV [10] = '{8'h01, 8'h00, 8'h01, 8'h08, 8'h00, 8'h00, 8'h00, 8'h01, 8'h07, 8'h3F};
    localparam logic [7:0] RM [10] = '{8'h01, 8'h70, 8'h0F, 8'h3F, 8'h3F, 8'hFF, 8'h0F, 8'h7F, 8'h7F, 8'hFF};
    // Reference code, P, J, D upper, D lower, R field, reference divisor
    localparam logic [7:0] SY [3][7] = '{'{8'h00, 8'h01, 8'h20, 8'h00, 8'h00, 8'h0F, 8'h01},
                                         '{8'h10, 8'h01, 8'h0B, 8'h09, 8'h0F, 8'h00, 8'h04},
                                         '{8'h30, 8'h01, 8'h08, 8'h13, 8'h88, 8'h00, 8'h02}};
    logic                clk, sys_rst, win, s_q, l_q;
    apcc_pkg::apcc_req_t req;
    apcc_pkg::apcc_sel_t clk_sel;
    logic [7:0]          rdata, rv;
    logic                h_run, h_mclk, h_sclk, h_lrck, h_gref;
    logic [15:0]         h_half;
    logic [9:0]          h_ratio;
    logic                sclk_out, sclk_oe_n, lrck_out, lrck_oe_n;
    logic                auto_active, clk_fault, dsp_clk_en, fs_tick;
    int                  miscompares, comparisons, n_m, n_t, n_d, n_s, gap, mark;
    longint              e;

    apcc_audio_host host (.run(h_run), .half_ps(h_half), .ratio(h_ratio),
                          .mclk(h_mclk), .sclk(h_sclk), .lrck(h_lrck), .gref(h_gref));
    apcc_clock_config #(.IDLE_TIMEOUT(8000)) dut (
        .clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
        .mclk_in(h_mclk), .sclk_in(sclk_oe_n ? h_sclk : sclk_out),
        .lrck_in(lrck_oe_n ? h_lrck : lrck_out), .gpio_ref_in(h_gref),
        .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .lrck_out(lrck_out), .lrck_oe_n(lrck_oe_n),
        .clk_sel(clk_sel), .auto_active(auto_active), .clk_fault(clk_fault),
        .dsp_clk_en(dsp_clk_en), .fs_tick(fs_tick));

    initial clk = 1'b0;
    always #2 clk = ~clk;

    always @(posedge h_mclk) if (win) n_m++;
    always @(posedge clk) begin
        if (win) begin
            n_t += int'(fs_tick);
            n_d += int'(dsp_clk_en);
            if (sclk_out && !s_q) n_s++;
            if (lrck_out && !l_q) begin
                gap = n_s - mark;
                mark = n_s;
            end
        end
        s_q <= sclk_out;
        l_q <= lrck_out;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        req.rd = 1'b0;
        d = rdata;
    endtask
    function automatic logic [7:0] near(input longint a, input longint b);
        return (a - b <= 2 && b - a <= 2) ? 8'h01 : 8'h00;
    endfunction
    task automatic window(input int edges);
        @(negedge clk);
        {n_m, n_t, n_d, n_s} = '0;
        win = 1'b1;
        repeat (edges) @(posedge h_mclk);
        @(negedge clk);
        win = 1'b0;
    endtask
    task automatic finish_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #380000;
        miscompares++;
        finish_test;
    end

    initial begin
        {req, sys_rst, win, h_run, s_q, l_q} = '0;
        sys_rst = 1'b1;
        h_half = 16'd20345;
        h_ratio = 10'd512;
        {miscompares, comparisons, gap, mark} = '0;
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 10; i++) begin
            rd(RA[i], rv); check(rv, RV[i]);
            wr(RA[i], 8'hFF);
            rd(RA[i], rv); check(rv, RM[i]);
            wr(RA[i], RV[i]);
        end
        wr(8'h30, 8'hFF);
        rd(8'h30, rv); check(rv, 8'h00);
        $display("test registers done");
        repeat (10) @(negedge clk);
        check({7'h0, clk_fault}, 8'h01);
        check({7'h0, auto_active}, 8'h00);
        wr(8'h25, 8'h02);
        repeat (4) @(negedge clk);
        check({7'h0, clk_fault}, 8'h00);
        $display("test fault done");
        wr(8'h25, 8'h00);
        h_run = 1'b1;
        for (int i = 0; i < 2; i++) begin
            h_ratio = (i == 0) ? 10'd512 : 10'd256;
            repeat (16000) @(negedge clk);
            rd(8'h5E, rv); check(rv, (i == 0) ? 8'h5A : 8'h3B);
            check({5'h0, clk_sel}, (i == 0) ? 8'h00 : 8'h07);
            check({7'h0, auto_active}, 8'h01);
        end
        $display("test detect done");
        wr(8'h25, 8'h01);
        wr(8'h1B, 8'h03);
        repeat (4) @(negedge clk);
        check({7'h0, auto_active}, 8'h00);
        for (int i = 0; i < 3; i++) begin
            for (int f = 0; f < 6; f++) wr(RA[f + 1], SY[i][f]);
            window(1200);
            e = longint'(n_m / SY[i][6]) * (SY[i][5] + 1) * (SY[i][2] * 10000 + {SY[i][3][5:0], SY[i][4]});
            check(near(n_t, e / (20480000 * SY[i][1])), 8'h01);
            check(near(n_d, n_m / SY[i][6] / 4), 8'h01);
        end
        wr(8'h04, 8'h00);
        window(600);
        check(8'(n_t + n_d), 8'h00);
        wr(8'h04, 8'h01);
        $display("test synth done");
        wr(8'h20, 8'h01);
        wr(8'h21, 8'h03);
        wr(8'h09, 8'h01);
        repeat (200) @(negedge clk);
        window(400);
        check({6'h0, sclk_oe_n, lrck_oe_n}, 8'h00);
        check(8'(gap), 8'h04);
        check(near(2 * n_s, n_m), 8'h01);
        $display("test master done");
        finish_test;
    end
endmodule // test_audio_pll_clock_config

bind apcc_clock_config apcc_clock_config_monitor #(.IDLE_TIMEOUT(IDLE_TIMEOUT)) u_mon (
    .clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata), .mclk_in(mclk_in), .sclk_in(sclk_in),
    .lrck_in(lrck_in), .gpio_ref_in(gpio_ref_in), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
    .lrck_out(lrck_out), .lrck_oe_n(lrck_oe_n), .clk_sel(clk_sel), .auto_active(auto_active),
    .clk_fault(clk_fault), .dsp_clk_en(dsp_clk_en), .fs_tick(fs_tick));

`default_nettype wire
